/* File: include/ada_pkg.sv */
// ----------------------------------------------------------------
// antenna driver auto control: shared constants and types
// ----------------------------------------------------------------
package ada_pkg;
    // host register addresses
    localparam logic [5:0] ADA_AUTO_ADDR = 6'h15;
    localparam logic [5:0] ADA_SEL_ADDR = 6'h16;
    // reset values
    localparam logic [7:0] ADA_AUTO_RST = 8'h00;
    localparam logic [7:0] ADA_SEL_RST = 8'h10;
    // field positions in the auto control register
    localparam int ADA_AUTO_RSVD_BIT = 4;
    localparam int ADA_INIT_CA_BIT = 2;
    // driver source codes
    localparam logic [1:0] ADA_SRC_TRISTATE = 2'h0;
    localparam logic [1:0] ADA_SRC_CODER = 2'h1;
    localparam logic [1:0] ADA_SRC_AUX_SIGNAL_INPUT_PIN = 2'h2;
    localparam logic [1:0] ADA_SRC_HIGH = 2'h3;
    // auxiliary output codes handled here
    localparam logic [3:0] ADA_AUX_TRISTATE = 4'h0;
    localparam logic [3:0] ADA_AUX_LOW = 4'h1;
    localparam logic [3:0] ADA_AUX_HIGH = 4'h2;
    localparam logic [3:0] ADA_AUX_ENVELOPE = 4'h4;
    localparam logic [3:0] ADA_AUX_TX_DATA = 4'h5;
    // timing: clock period and delay times
    localparam int ADA_CLK_NS = 40;
    localparam int ADA_ACTIVE_DELAY_NS = 60000;
    localparam int ADA_INITIAL_DELAY_NS = 300000;
    localparam int ADA_SLOT_NS = 20000;
    // least times round up to whole cycles
    localparam int ADA_ACTIVE_DELAY_CYC =
        (ADA_ACTIVE_DELAY_NS + ADA_CLK_NS - 1) / ADA_CLK_NS;
    localparam int ADA_INITIAL_DELAY_CYC =
        (ADA_INITIAL_DELAY_NS + ADA_CLK_NS - 1) / ADA_CLK_NS;
    localparam int ADA_SLOT_CYC = (ADA_SLOT_NS + ADA_CLK_NS - 1) / ADA_CLK_NS;
    localparam int ADA_TMR_W = 16;
    localparam logic [2:0] ADA_LFSR_SEED = 3'h1;

    // auto control register layout
    typedef struct packed {
        logic auto_field_off;
        logic force_full_depth_keying;
        logic field_wake_enable;
        logic reserved;
        logic response_collision_avoid_enable;
        logic initial_collision_avoid_enable;
        logic driver_two_auto_enable;
        logic driver_one_auto_enable;
    } ada_auto_t;

    // driver source select register layout
    typedef struct packed {
        logic [1:0] reserved;
        logic [1:0] driver_source_field;
        logic [3:0] aux_output_select_field;
    } ada_sel_t;

    // per-driver inversion controls, index 0 is driver one
    typedef struct packed {
        logic [1:0] invert_when_on;
        logic [1:0] invert_when_off;
    } ada_inv_t;

    // controller states
    typedef enum logic [2:0] {
        ADA_IDLE,
        ADA_FIELD,
        ADA_ACTIVE,
        ADA_SLOT,
        ADA_INITIAL
    } ada_state_t;
endpackage : ada_pkg

/* File: core/ada_timer.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// down counter: load a count, pulse done when it runs out
// ----------------------------------------------------------------
module ada_timer #(
    parameter int W = 16
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic start_i, // load and start, restarts if busy
    input wire logic [W-1:0] count_i, // cycles until done
    output logic done_o // one cycle pulse
);
    import ada_pkg::*;

    logic [W-1:0] cnt_r, cnt_nxt; // remaining cycles
    logic run_r, run_nxt; // counting
    logic done_r, done_nxt;

    // next state of the counter
    always_comb begin
        cnt_nxt = cnt_r;
        run_nxt = run_r;
        done_nxt = 1'b0;
        if (start_i) begin
            // a zero count still takes one cycle
            cnt_nxt = (count_i == '0) ? W'(1) : count_i;
            run_nxt = 1'b1;
        end else if (run_r) begin
            cnt_nxt = cnt_r - W'(1);
            if (cnt_r == W'(1)) begin
                run_nxt = 1'b0;
                done_nxt = 1'b1;
            end
        end
    end

    // registers only
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_r <= '0;
            run_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            run_r <= run_nxt;
            done_r <= done_nxt;
        end
    end

    assign done_o = done_r;
endmodule : ada_timer
`default_nettype wire

/* File: core/ada_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - auto off drops drivers after last bit
// - force bit demands full depth keying
// - field detect wakes from soft power-down
// - reserved bits read back as zero
// - response avoidance enables, random slot factor
// - initial avoidance clears itself at field on
// - driver two on after field gone, delay
// - initial mode: driver two needs quiet time
// - driver one on after field gone, delay
// - initial mode: driver one needs quiet time
// - source field picks what feeds drivers
// - power-down tristates only for tristate source
// - constant high passes through inversion controls
// - inversion per driver by on/off state
// - aux select routes levels or streams
module ada_ctrl #(
    parameter int ACTIVE_DELAY_CYC = ada_pkg::ADA_ACTIVE_DELAY_CYC,
    parameter int INITIAL_DELAY_CYC = ada_pkg::ADA_INITIAL_DELAY_CYC,
    parameter int SLOT_CYC = ada_pkg::ADA_SLOT_CYC
) (
    input wire logic clock_i,
    input wire logic reset_i,
    // host register port
    input wire logic [5:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // state held elsewhere in the chip
    input wire logic [1:0] host_driver_enable_i, // level, per driver
    input wire ada_pkg::ada_inv_t inversion_i,
    input wire logic soft_powerdown_i,
    input wire logic last_bit_sent_i, // pulse from the coder
    input wire logic coder_envelope_i,
    input wire logic serial_tx_data_i,
    // pins
    input wire logic field_detect_i, // external field detector
    input wire logic aux_signal_input_pin_i,
    output logic [1:0] antenna_driver_o, // [0] one, [1] two
    output logic [1:0] antenna_driver_oe_n_o,
    output logic aux_signal_output_pin_o,
    output logic aux_signal_output_pin_oe_n_o,
    // to the modulator and power control
    output logic full_depth_keying_o,
    output logic response_collision_avoid_o,
    output logic [1:0] slot_factor_o,
    output logic wake_request_o,
    output logic [1:0] driver_on_o
);
    import ada_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] sync1_r; // first stage, only read by second stage
    logic [1:0] sync2_r; // [0] field, [1] signal input
    logic field_s;
    logic aux_signal_input_pin_s;

    // two flops before any logic looks at the pins
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            sync1_r <= 2'h0;
            sync2_r <= 2'h0;
        end else begin
            sync1_r <= {aux_signal_input_pin_i, field_detect_i};
            sync2_r <= sync1_r;
        end
    end
    assign field_s = sync2_r[0];
    assign aux_signal_input_pin_s = sync2_r[1];

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    ada_auto_t auto_r, auto_nxt; // auto control register
    ada_sel_t sel_r, sel_nxt; // driver source select register
    logic [7:0] rdata_r, rdata_nxt;
    logic init_clear; // hardware clear of initial avoidance

    // register writes and reads; a host write wins over the
    // self clear so a fresh request is never dropped
    always_comb begin
        auto_nxt = auto_r;
        sel_nxt = sel_r;
        rdata_nxt = rdata_r;
        if (init_clear) begin
            auto_nxt.initial_collision_avoid_enable = 1'b0;
        end
        if (reg_wr_i && reg_addr_i == ADA_AUTO_ADDR) begin
            auto_nxt = reg_wdata_i;
        end
        if (reg_wr_i && reg_addr_i == ADA_SEL_ADDR) begin
            sel_nxt = reg_wdata_i;
        end
        auto_nxt.reserved = 1'b0;
        sel_nxt.reserved = 2'h0;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                ADA_AUTO_ADDR: rdata_nxt = auto_r;
                ADA_SEL_ADDR: rdata_nxt = sel_r;
                default: rdata_nxt = 8'h00; // unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            auto_r <= ADA_AUTO_RST;
            sel_r <= ADA_SEL_RST;
            rdata_r <= 8'h00;
        end else begin
            auto_r <= auto_nxt;
            sel_r <= sel_nxt;
            rdata_r <= rdata_nxt;
        end
    end
    assign reg_rdata_o = rdata_r;

    // ------------------------------------------------------------
    // slot factor generator
    // ------------------------------------------------------------
    logic [2:0] lfsr_r, lfsr_nxt; // free running, never all zero

    always_comb begin
        lfsr_nxt = {lfsr_r[1:0], lfsr_r[2] ^ lfsr_r[1]};
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            lfsr_r <= ADA_LFSR_SEED;
        end else begin
            lfsr_r <= lfsr_nxt;
        end
    end

    // ------------------------------------------------------------
    // collision avoidance sequencer
    // ------------------------------------------------------------
    ada_state_t state_r, state_nxt;
    logic [1:0] slot_n_r, slot_n_nxt; // n latched only when a slot wait starts
    logic tmr_start;
    logic [ADA_TMR_W-1:0] tmr_count;
    logic tmr_done;
    logic turn_on; // switch on auto enabled drivers
    logic [1:0] auto_en;

    assign auto_en = {auto_r.driver_two_auto_enable,
                      auto_r.driver_one_auto_enable};

    // a field seen during any wait aborts it; the attempt is
    // retried only after the field is gone again
    always_comb begin
        state_nxt = state_r;
        slot_n_nxt = slot_n_r;
        tmr_start = 1'b0;
        tmr_count = ADA_TMR_W'(ACTIVE_DELAY_CYC);
        turn_on = 1'b0;
        init_clear = 1'b0;
        unique case (state_r)
            ADA_IDLE: begin
                if (field_s) begin
                    state_nxt = ADA_FIELD;
                end else if (auto_r.initial_collision_avoid_enable &&
                             auto_en != 2'h0) begin
                    tmr_start = 1'b1;
                    tmr_count = ADA_TMR_W'(INITIAL_DELAY_CYC);
                    state_nxt = ADA_INITIAL;
                end
            end
            ADA_FIELD: begin
                if (!field_s) begin
                    if (auto_en != 2'h0 &&
                        !auto_r.initial_collision_avoid_enable) begin
                        tmr_start = 1'b1;
                        state_nxt = ADA_ACTIVE;
                    end else begin
                        state_nxt = ADA_IDLE;
                    end
                end
            end
            ADA_ACTIVE: begin
                if (field_s) begin
                    state_nxt = ADA_FIELD;
                end else if (tmr_done) begin
                    if (auto_r.response_collision_avoid_enable &&
                        lfsr_r[1:0] != 2'h0) begin
                        slot_n_nxt = lfsr_r[1:0];
                        tmr_start = 1'b1;
                        tmr_count = ADA_TMR_W'(SLOT_CYC *
                                               int'(lfsr_r[1:0]));
                        state_nxt = ADA_SLOT;
                    end else begin
                        turn_on = 1'b1;
                        state_nxt = ADA_IDLE;
                    end
                end
            end
            ADA_SLOT: begin
                if (field_s) begin
                    state_nxt = ADA_FIELD;
                end else if (tmr_done) begin
                    turn_on = 1'b1;
                    state_nxt = ADA_IDLE;
                end
            end
            ADA_INITIAL: begin
                if (field_s) begin
                    state_nxt = ADA_FIELD;
                end else if (tmr_done) begin
                    turn_on = 1'b1;
                    init_clear = 1'b1;
                    state_nxt = ADA_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            state_r <= ADA_IDLE;
            slot_n_r <= 2'h0;
        end else begin
            state_r <= state_nxt;
            slot_n_r <= slot_n_nxt;
        end
    end

    ada_timer #(
        .W(ADA_TMR_W)
    ) u_timer (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .start_i(tmr_start),
        .count_i(tmr_count),
        .done_o(tmr_done)
    );

    // ------------------------------------------------------------
    // driver enable state and pin outputs
    // ------------------------------------------------------------
    logic [1:0] on_r, on_nxt; // driver is switched on
    logic [1:0] host_en_q_r, host_en_q_nxt; // previous host enable
    logic [1:0] drv_r, drv_nxt;
    logic [1:0] drv_oe_n_r, drv_oe_n_nxt;
    logic aux_r, aux_nxt;
    logic aux_oe_n_r, aux_oe_n_nxt;
    logic wake_r, wake_nxt;
    logic field_q_r; // previous synchronised field
    logic src_level; // selected source before inversion

    // source selection, shared by both drivers
    always_comb begin
        unique case (sel_r.driver_source_field)
            ADA_SRC_TRISTATE: src_level = 1'b0;
            ADA_SRC_CODER: src_level = coder_envelope_i;
            ADA_SRC_AUX_SIGNAL_INPUT_PIN: src_level = aux_signal_input_pin_s;
            ADA_SRC_HIGH: src_level = 1'b1;
        endcase
    end

    // per driver: enable bookkeeping and inverted pin level;
    // soft power-down is deliberately not looked at here
    always_comb begin
        host_en_q_nxt = host_driver_enable_i;
        for (int k = 0; k < 2; k++) begin
            on_nxt[k] = on_r[k];
            if (host_driver_enable_i[k] && !host_en_q_r[k]) begin
                on_nxt[k] = 1'b1;
            end
            if (!host_driver_enable_i[k] && host_en_q_r[k]) begin
                on_nxt[k] = 1'b0;
            end
            if (turn_on && auto_en[k]) begin
                on_nxt[k] = 1'b1;
            end
            if (last_bit_sent_i && auto_r.auto_field_off) begin
                on_nxt[k] = 1'b0;
            end
            drv_nxt[k] = src_level ^ (on_r[k] ?
                inversion_i.invert_when_on[k] :
                inversion_i.invert_when_off[k]);
            drv_oe_n_nxt[k] = (sel_r.driver_source_field ==
                               ADA_SRC_TRISTATE);
        end
    end

    // auxiliary output and wake request
    always_comb begin
        aux_nxt = 1'b0;
        aux_oe_n_nxt = 1'b0;
        unique case (sel_r.aux_output_select_field)
            ADA_AUX_TRISTATE: aux_oe_n_nxt = 1'b1;
            ADA_AUX_LOW: aux_nxt = 1'b0;
            ADA_AUX_HIGH: aux_nxt = 1'b1;
            ADA_AUX_ENVELOPE: aux_nxt = coder_envelope_i;
            ADA_AUX_TX_DATA: aux_nxt = serial_tx_data_i;
            default: aux_nxt = 1'b0; // other sources live elsewhere
        endcase
        wake_nxt = auto_r.field_wake_enable && soft_powerdown_i &&
                   field_s && !field_q_r;
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            on_r <= 2'h0;
            host_en_q_r <= 2'h0;
            drv_r <= 2'h0;
            drv_oe_n_r <= 2'h3;
            aux_r <= 1'b0;
            aux_oe_n_r <= 1'b1;
            wake_r <= 1'b0;
            field_q_r <= 1'b0;
        end else begin
            on_r <= on_nxt;
            host_en_q_r <= host_en_q_nxt;
            drv_r <= drv_nxt;
            drv_oe_n_r <= drv_oe_n_nxt;
            aux_r <= aux_nxt;
            aux_oe_n_r <= aux_oe_n_nxt;
            wake_r <= wake_nxt;
            field_q_r <= field_s;
        end
    end

    assign antenna_driver_o = drv_r;
    assign antenna_driver_oe_n_o = drv_oe_n_r;
    assign aux_signal_output_pin_o = aux_r;
    assign aux_signal_output_pin_oe_n_o = aux_oe_n_r;
    assign wake_request_o = wake_r;
    assign driver_on_o = on_r;
    assign full_depth_keying_o = auto_r.force_full_depth_keying;
    assign response_collision_avoid_o =
        auto_r.response_collision_avoid_enable;
    assign slot_factor_o = slot_n_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_auto_off_drop: assert property (
        @(posedge clock_i) disable iff (reset_i)
        last_bit_sent_i && auto_r.auto_field_off |=> on_r == 2'h0)
        else $error("drivers not off after last bit");

    // bit 4 is only reserved in the auto register; in the select
    // register it is the low source bit, so key on the address
    a_reserved_zero: assert property (
        @(posedge clock_i) disable iff (reset_i)
        reg_rd_i && reg_addr_i == ADA_AUTO_ADDR
        |=> !reg_rdata_o[ADA_AUTO_RSVD_BIT])
        else $error("reserved auto bit not zero");

    a_sel_rsvd_zero: assert property (
        @(posedge clock_i) disable iff (reset_i)
        reg_rd_i && reg_addr_i == ADA_SEL_ADDR
        |=> reg_rdata_o[7:6] == 2'h0)
        else $error("reserved select bits not zero");

    a_init_self_clear: assert property (
        @(posedge clock_i) disable iff (reset_i)
        state_r == ADA_INITIAL && tmr_done && !field_s && !reg_wr_i
        |=> !auto_r.initial_collision_avoid_enable)
        else $error("initial avoidance bit not cleared");

    a_init_quiet: assert property (
        @(posedge clock_i) disable iff (reset_i)
        state_r == ADA_INITIAL && field_s |=> state_r == ADA_FIELD)
        else $error("field during initial wait not aborting");

    a_auto_turn_on: assert property (
        @(posedge clock_i) disable iff (reset_i)
        turn_on && auto_en[0] && !last_bit_sent_i |=> on_r[0])
        else $error("driver one not switched on");

    a_tristate_src: assert property (
        @(posedge clock_i) disable iff (reset_i)
        sel_r.driver_source_field == ADA_SRC_TRISTATE &&
        $stable(sel_r) |=> antenna_driver_oe_n_o == 2'h3)
        else $error("drivers not tristate");

    a_high_inverted: assert property (
        @(posedge clock_i) disable iff (reset_i)
        sel_r.driver_source_field == ADA_SRC_HIGH && on_r[1] &&
        inversion_i.invert_when_on[1]
        |=> !antenna_driver_o[1])
        else $error("inverted high level wrong");

    a_aux_high: assert property (
        @(posedge clock_i) disable iff (reset_i)
        sel_r.aux_output_select_field == ADA_AUX_HIGH
        |=> aux_signal_output_pin_o && !aux_signal_output_pin_oe_n_o)
        else $error("aux output not high");

    a_wake_field: assert property (
        @(posedge clock_i) disable iff (reset_i)
        $rose(field_s) && auto_r.field_wake_enable && soft_powerdown_i
        |=> wake_request_o ##1 !wake_request_o)
        else $error("wake request missing");
endmodule : ada_ctrl
`default_nettype wire

/* File: sim/ada_field_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// external field detector seen by the block
// ----------------------------------------------------------------
module ada_field_model (
    input wire logic clock_i,
    input wire logic field_cmd_i, // bench asks for a foreign field
    output logic field_detect_o // detector pin level
);
    // the comparator settles a little after the edge, never on it
    always @(posedge clock_i) begin
        field_detect_o <= #3 field_cmd_i;
    end
endmodule : ada_field_model
`default_nettype wire

/* File: sim/ada_ctrl_tb.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// self-checking bench for the driver auto control
// ----------------------------------------------------------------
module ada_ctrl_tb;
    import ada_pkg::*;
    localparam int ACT = 8; // short delays keep the run brief
    localparam int INI = 16;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic [5:0] addr = 6'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic [1:0] hen = 2'h0; // host driver enables
    ada_inv_t inv = 4'h0;
    logic pd = 1'b0; // soft power-down
    logic last = 1'b0;
    logic env = 1'b0;
    logic txd = 1'b0;
    logic aux_signal_input_pin = 1'b0;
    logic fcmd = 1'b0;
    logic field;
    logic [1:0] drv;
    logic [1:0] drv_oe_n;
    logic [1:0] drv_on;
    logic [1:0] slot; // random slot factor of the last attempt that waited slots
    logic aux;
    logic aux_oe_n;
    logic fdk;
    logic rca;
    logic wake;
    logic [7:0] v;
    logic [1:0] s;
    logic lvl;
    int n_fail = 0;
    int n_tests = 0;
    int hit;

    always #20 clock_i = ~clock_i;

    ada_ctrl #(.ACTIVE_DELAY_CYC(ACT), .INITIAL_DELAY_CYC(INI),
        .SLOT_CYC(4)) u_ada_ctrl (
        .clock_i(clock_i), .reset_i(reset_i), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .host_driver_enable_i(hen),
        .inversion_i(inv), .soft_powerdown_i(pd), .last_bit_sent_i(last),
        .coder_envelope_i(env), .serial_tx_data_i(txd),
        .field_detect_i(field), .aux_signal_input_pin_i(aux_signal_input_pin),
        .antenna_driver_o(drv), .antenna_driver_oe_n_o(drv_oe_n),
        .aux_signal_output_pin_o(aux),
        .aux_signal_output_pin_oe_n_o(aux_oe_n),
        .full_depth_keying_o(fdk), .response_collision_avoid_o(rca),
        .slot_factor_o(slot), .wake_request_o(wake), .driver_on_o(drv_on));

    ada_field_model u_ada_field_model (.clock_i(clock_i),
        .field_cmd_i(fcmd), .field_detect_o(field));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock_i);
        wr <= 1'b0;
    endtask : wr_reg

    // one spare edge: rdata holds until the next read anyway
    task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
        @(posedge clock_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock_i);
        rd <= 1'b0;
        @(posedge clock_i);
        #1 d = rdata;
    endtask : rd_reg

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : cyc

    // bounded wait for the driver state, then compare it
    task automatic wait_on(input logic [1:0] e, input int lim);
        int k;
        k = 0;
        while (drv_on !== e && k < lim) begin
            cyc(1);
            k++;
        end
        chk({6'h00, drv_on}, {6'h00, e});
    endtask : wait_on

    // pin level from source level and per-driver inversion
    function automatic logic [1:0] exp_drv(input logic l,
        input logic [1:0] on, input ada_inv_t iv);
        for (int i = 0; i < 2; i++) begin
            exp_drv[i] = l ^ (on[i] ? iv.invert_when_on[i] :
                iv.invert_when_off[i]);
        end
    endfunction : exp_drv

    task automatic end_of_test;
        $display("TB: tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    // whole run needs a few hundred cycles; this is over a hundred times that
    initial begin
        #(40 * 40000);
        n_fail++;
        end_of_test();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        v = 8'($urandom(25));
        repeat (2) @(posedge clock_i);
        reset_i <= 1'b0;
        rd_reg(ADA_AUTO_ADDR, v);
        chk(v, ADA_AUTO_RST);
        rd_reg(ADA_SEL_ADDR, v);
        chk(v, ADA_SEL_RST);
        rd_reg(6'h17, v);
        chk(v, 8'h00);
        // random register contents, auto enables kept clear
        repeat (6) begin
            wr_reg(ADA_AUTO_ADDR, 8'($urandom) & 8'hF8);
            rd_reg(ADA_AUTO_ADDR, v);
            chk({7'h00, fdk}, {7'h00, v[6]});
            chk({7'h00, rca}, {7'h00, v[3]});
            chk(v & 8'h10, 8'h00);
            wr_reg(ADA_SEL_ADDR, 8'($urandom));
            rd_reg(ADA_SEL_ADDR, v);
            chk(v & 8'hC0, 8'h00);
        end
        wr_reg(ADA_AUTO_ADDR, 8'h00);
        // every source code, random inversion and power-down
        for (int i = 0; i < 8; i++) begin
            s = i[1:0];
            wr_reg(ADA_SEL_ADDR, {2'h0, s, 4'h0});
            inv <= 4'($urandom);
            env <= 1'($urandom);
            aux_signal_input_pin <= 1'($urandom);
            pd <= 1'($urandom);
            cyc(5);
            lvl = (s == ADA_SRC_CODER) ? env :
                (s == ADA_SRC_AUX_SIGNAL_INPUT_PIN) ? aux_signal_input_pin : 1'b1;
            chk({6'h00, drv_oe_n}, (s == 2'h0) ? 8'h03 : 8'h00);
            if (s != 2'h0) begin
                chk({6'h00, drv}, {6'h00, exp_drv(lvl, 2'h0, inv)});
            end
        end
        pd <= 1'b0;
        // auxiliary pin codes
        for (int i = 0; i < 5; i++) begin
            v = (i == 3) ? 8'h05 : (i == 4) ? 8'h04 : i[7:0];
            wr_reg(ADA_SEL_ADDR, 8'h10 | v);
            txd <= 1'($urandom);
            cyc(3);
            chk({7'h00, aux_oe_n}, {7'h00, v == 8'h00});
            if (v != 8'h00) begin
                lvl = (v == 8'h01) ? 1'b0 : (v == 8'h02) ? 1'b1 :
                    (v == 8'h04) ? env : txd;
                chk({7'h00, aux}, {7'h00, lvl});
            end
        end
        // host switches drivers on under the constant high source
        wr_reg(ADA_SEL_ADDR, 8'h30);
        // driver two inverts when on, so the inverted high is seen
        inv <= 4'($urandom) | 4'h8;
        hen <= 2'h3;
        cyc(4);
        chk({6'h00, drv}, {6'h00, exp_drv(1'b1, 2'h3, inv)});
        hen <= 2'h0;
        cyc(4);
        chk({6'h00, drv}, {6'h00, exp_drv(1'b1, 2'h0, inv)});
        // active path with response avoidance, then auto off;
        // n slots of 4 cycles follow the delay when n is not zero
        wr_reg(ADA_AUTO_ADDR, 8'h8B);
        fcmd <= 1'b1;
        cyc(6);
        fcmd <= 1'b0;
        cyc(ACT);
        chk({6'h00, drv_on}, 8'h00);
        hit = ACT;
        while (drv_on !== 2'h3 && hit < 40) begin
            cyc(1);
            hit++;
        end
        chk({6'h00, drv_on}, 8'h03);
        chk(hit[7:0], (slot == 2'h0) ? 8'(ACT + 5) :
            8'(ACT + 6 + 4 * slot));
        @(posedge clock_i);
        last <= 1'b1;
        @(posedge clock_i);
        last <= 1'b0;
        cyc(2);
        chk({6'h00, drv_on}, 8'h00);
        // initial avoidance with driver two enabled, aborted once
        wr_reg(ADA_AUTO_ADDR, 8'h06);
        cyc(8);
        fcmd <= 1'b1;
        cyc(30);
        chk({6'h00, drv_on}, 8'h00);
        fcmd <= 1'b0;
        wait_on(2'h2, 60);
        rd_reg(ADA_AUTO_ADDR, v);
        chk(v, 8'h02);
        // field wakes the chip from soft power-down
        wr_reg(ADA_AUTO_ADDR, 8'h20);
        pd <= 1'b1;
        fcmd <= 1'b1;
        hit = 0;
        repeat (8) begin
            cyc(1);
            if (wake === 1'b1) begin
                hit++;
            end
        end
        chk(hit[7:0], 8'h01);
        end_of_test();
    end
endmodule : ada_ctrl_tb
`default_nettype wire
